/* rtl/wdt_timeout.v */
// watchdog timeout counter with wishbone slave and reset generator
// Behaviour
// - counts on oscillator clock
// - stop instruction clears the prescaler
// - service write clears counter, prescaler stages 12-5
// - service read returns reset vector low byte
// - power-on clears prescaler after 4096 cycles
// - internal reset clears prescaler and counter
// - disable input follows config latch
// - rate select follows config latch
// - service register at ffff restarts timeout
// - no interrupt, only reset on overflow
// - monitor via irq test voltage disables while held
// - monitor via blank vectors disables until power-on
// - keeps counting in wait mode
// - stop gates clock and clears prescaler
// - disabled stop gives illegal-opcode reset
// - break with reset-pin test voltage disables
// - 6-bit counter after 12-bit prescaler
// - overflow at 8176 or 262128 cycles (code: 8128 or 260096, less prescaler bits 3:0 kept by service)
// - reset low 32 cycles, sets status flag
// - disable bit one disables, zero enables
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`include "wdt_defs.vh"
module wdt_timeout
(
	clock,
	nrst,
	wb_cyc_i,
	wb_stb_i,
	wb_we_i,
	wb_adr_i,
	wb_sel_i,
	wb_dat_i,
	wb_dat_o,
	wb_ack_o,
	stopExec,
	waitMode,
	monitorMode,
	blankVectors,
	breakActive,
	irqTestVoltage,
	rstTestVoltage,
	resetPinN,
	internalReset
);
	parameter PORCYCLES = `WDT_POR_CYCLES;
	localparam RSTCYCLES = `WDT_RST_CYCLES;
	input  wire        clock;
	input  wire        nrst;
	input  wire        wb_cyc_i;
	input  wire        wb_stb_i;
	input  wire        wb_we_i;
	input  wire [15:0] wb_adr_i;
	input  wire [3:0]  wb_sel_i;
	input  wire [31:0] wb_dat_i;
	output reg  [31:0] wb_dat_o;
	output reg         wb_ack_o;
	input  wire        stopExec;
	input  wire        waitMode;
	input  wire        monitorMode;
	input  wire        blankVectors;
	input  wire        breakActive;
	input  wire        irqTestVoltage;
	input  wire        rstTestVoltage;
	output reg         resetPinN;
	output reg         internalReset;

	reg         rstSync1_q;
	reg         rstn_q;
	wire        irqTstS;
	wire        rstTstS;
	reg  [2:0]  cfg_q;
	reg  [2:0]  status_q;
	reg  [7:0]  vecLo_q;
	reg  [5:0]  wdCount_q;
	reg  [5:0]  pulseCnt_q;
	reg  [12:0] porCnt_q;
	reg         porDone_q;
	reg         blankLock_q;
	reg         stopped_q;
	reg         tapPrev_q;
	wire [11:0] preCount;
	wire        busReq;
	wire        svcWrite;
	wire        wdDisable;
	wire        wdRateFast;
	wire        wdOff;
	wire        tap;
	wire        tapRise;
	wire        overflow;
	wire        stopLegal;
	wire        stopIllegal;
	wire        preClear;

	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rstSync1_q <= 1'b0;
			rstn_q     <= 1'b0;
		end
		else
		begin
			rstSync1_q <= 1'b1;
			rstn_q     <= rstSync1_q;
		end
	end

	wdt_sync u_irqSync
	(
		.clock (clock),
		.nrst  (rstn_q),
		.din   (irqTestVoltage),
		.dout  (irqTstS)
	);

	wdt_sync u_rstSync
	(
		.clock (clock),
		.nrst  (rstn_q),
		.din   (rstTestVoltage),
		.dout  (rstTstS)
	);

	assign busReq     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign svcWrite   = busReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == `WDT_ADDR_SERVICE);
	assign wdDisable  = cfg_q[`WDT_CFG_DISABLE];
	assign wdRateFast = cfg_q[`WDT_CFG_RATE];
	assign stopLegal   = stopExec & cfg_q[`WDT_CFG_STOPEN];
	assign stopIllegal = stopExec & ~cfg_q[`WDT_CFG_STOPEN];

	// disable bit, blank-vector lock, monitor and break test-voltage disables
	assign wdOff = wdDisable
		| (monitorMode & (irqTstS | rstTstS))
		| blankLock_q
		| (breakActive & rstTstS);

	// fast tap: first rise at 2^6, then 63 x 2^7 = 8192-64; slow tap: 2^11 + 63 x 2^12
	assign tap      = wdRateFast ? preCount[`WDT_FAST_TAP] : preCount[`WDT_SLOW_TAP];
	assign tapRise  = tap & ~tapPrev_q;
	assign overflow = tapRise & (wdCount_q == 6'h3f) & ~wdOff;
	assign preClear = stopExec | internalReset | (porCnt_q == PORCYCLES[12:0] - 13'h0001);

	wdt_prescaler u_pre
	(
		.clock      (clock),
		.rstn       (rstn_q),
		.clkEn      (~stopped_q),
		.clearAll   (preClear),
		.clearUpper (svcWrite),
		.count      (preCount)
	);

	always @(posedge clock or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			porCnt_q    <= 13'h0000;
			porDone_q   <= 1'b0;
			blankLock_q <= 1'b0;
		end
		else
		begin
			if (!porDone_q)
			begin
				porCnt_q <= porCnt_q + 13'h0001;
				if (porCnt_q == PORCYCLES[12:0] - 13'h0001)
					porDone_q <= 1'b1;
			end
			if (monitorMode & blankVectors & ~irqTstS)
				blankLock_q <= 1'b1;
		end
	end

	always @(posedge clock or negedge rstn_q)
	begin
		if (!rstn_q)
			stopped_q <= 1'b0;
		else if (internalReset)
			stopped_q <= 1'b0;
		else if (stopLegal)
			stopped_q <= 1'b1;
		else if (svcWrite | ~waitMode & busReq)
			stopped_q <= stopped_q;
	end

	// watchdog counter; wait mode does not stop it
	always @(posedge clock or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			wdCount_q <= 6'h00;
			tapPrev_q <= 1'b0;
		end
		else
		begin
			tapPrev_q <= tap;
			if (internalReset | svcWrite | stopExec)
				wdCount_q <= 6'h00;
			else if (tapRise & ~wdOff & ~stopped_q)
				wdCount_q <= wdCount_q + 6'h01;
		end
	end

	// reset pulse generator
	always @(posedge clock or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			pulseCnt_q    <= 6'h00;
			resetPinN     <= 1'b1;
			internalReset <= 1'b0;
			status_q      <= 3'h4;
		end
		else if (pulseCnt_q != 6'h00)
		begin
			pulseCnt_q    <= pulseCnt_q - 6'h01;
			resetPinN     <= (pulseCnt_q == 6'h01);
			internalReset <= (pulseCnt_q != 6'h01);
		end
		else if (overflow | stopIllegal)
		begin
			pulseCnt_q    <= RSTCYCLES[5:0];
			resetPinN     <= 1'b0;
			internalReset <= 1'b1;
			status_q      <= {1'b0, stopIllegal, overflow};
		end
	end

	// configuration latches, reset vector low byte and status readback
	always @(posedge clock or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			cfg_q    <= 3'h0;
			vecLo_q  <= `WDT_VECLO_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= busReq;
			wb_dat_o <= 32'h00000000;
			if (busReq & wb_we_i & wb_sel_i[0])
			begin
				if (wb_adr_i == `WDT_ADDR_CONFIG)
					cfg_q <= wb_dat_i[2:0];
				if (wb_adr_i == `WDT_ADDR_VECLO)
					vecLo_q <= wb_dat_i[7:0];
			end
			if (busReq & ~wb_we_i)
			begin
				case (wb_adr_i)
					`WDT_ADDR_SERVICE: wb_dat_o <= {24'h000000, vecLo_q};
					`WDT_ADDR_CONFIG:  wb_dat_o <= {29'h00000000, cfg_q};
					`WDT_ADDR_STATUS:  wb_dat_o <= {23'h000000, wdCount_q, status_q};
					`WDT_ADDR_VECLO:   wb_dat_o <= {24'h000000, vecLo_q};
					default:           wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // wdt_timeout

/* rtl/wdt_defs.vh */
// constants for the watchdog timeout block
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
`define WDT_ADDR_SERVICE   16'hffff
`define WDT_ADDR_CONFIG    16'hfff0
`define WDT_ADDR_STATUS    16'hfff4
`define WDT_ADDR_VECLO     16'hfff8
`define WDT_PRE_WIDTH      12
`define WDT_CNT_WIDTH      6
`define WDT_PRE_KEEP_MASK  12'h00f
`define WDT_FAST_TAP       6
`define WDT_SLOW_TAP       11
`define WDT_RST_CYCLES     32
`define WDT_POR_CYCLES     4096
`define WDT_CFG_DISABLE    0
`define WDT_CFG_RATE       1
`define WDT_CFG_STOPEN     2
`define WDT_ST_WATCHDOG    0
`define WDT_ST_ILLEGAL     1
`define WDT_ST_POR         2
`define WDT_VECLO_RESET    8'h00
`endif

/* rtl/wdt_sync.v */
// two-flop synchroniser for one level
`timescale 1ns/10ps
module wdt_sync
(
	clock,
	nrst,
	din,
	dout
);
	input  wire clock;
	input  wire nrst;
	input  wire din;
	output reg  dout;
	reg         stage1_q;

	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_q <= 1'b0;
			dout     <= 1'b0;
		end
		else
		begin
			stage1_q <= din;
			dout     <= stage1_q;
		end
	end
endmodule // wdt_sync

/* rtl/wdt_prescaler.v */
// shared 12-bit system prescaler
`timescale 1ns/10ps
`include "wdt_defs.vh"
module wdt_prescaler
(
	clock,
	rstn,
	clkEn,
	clearAll,
	clearUpper,
	count
);
	input  wire                        clock;
	input  wire                        rstn;
	input  wire                        clkEn;
	input  wire                        clearAll;
	input  wire                        clearUpper;
	output reg  [`WDT_PRE_WIDTH-1:0]   count;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count <= 12'h000;
		else if (clearAll)
			count <= 12'h000;
		else if (clearUpper)
			count <= count & `WDT_PRE_KEEP_MASK;
		else if (clkEn)
			count <= count + 12'h001;
	end
endmodule // wdt_prescaler

/* dv/wdt_cpu_model.sv */
// cpu side bus master model
`timescale 1ns/10ps
module wdt_cpu_model
(
	input  wire         clock,
	input  wire         wb_ack_o,
	input  wire  [31:0] wb_dat_o,
	output logic        wb_cyc_i = 1'b0,
	output logic        wb_stb_i = 1'b0,
	output logic        wb_we_i = 1'b0,
	output logic [15:0] wb_adr_i = 16'h0000,
	output logic [3:0]  wb_sel_i = 4'h0,
	output logic [31:0] wb_dat_i = 32'h00000000
);
	task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do
			@(posedge clock);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// released lines show no stale value
		wb_adr_i <= ~a;
		wb_dat_i <= ~d;
		@(posedge clock);
	endtask
endmodule // wdt_cpu_model

/* dv/wdt_timeout_monitor.sv */
// port checker for the watchdog block
`timescale 1ns/10ps
module wdt_timeout_monitor
(
	input wire        clock,
	input wire        nrst,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        resetPinN,
	input wire        internalReset
);
	logic [7:0] lowCnt_q;
	wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        svc = wb_ack_o && wb_we_i && wb_adr_i == 16'hffff;
	wire        rd = wb_ack_o && !wb_we_i;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// cycles spent with the pin low
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			lowCnt_q <= 8'h00;
		else
			lowCnt_q <= resetPinN ? 8'h00 : lowCnt_q + 8'h01;
	end
	chk_ack_late: assert property (req |=> wb_ack_o) else $error("late");
	chk_ack_long: assert property (wb_ack_o |=> !wb_ack_o) else $error("long");
	chk_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("unasked");
	chk_rd_upper: assert property (rd |-> wb_dat_o[31:8] == 24'h000000) else $error("upper");
	chk_rd_unmap: assert property (rd && wb_adr_i == 16'h1234 |-> wb_dat_o == 32'h00000000)
		else $error("unmapped");
	chk_pin_width: assert property ($rose(resetPinN) |-> lowCnt_q == 8'h20) else $error("width");
	chk_pin_hold: assert property ($fell(resetPinN) |=> (!resetPinN) [*8]) else $error("short");
	chk_svc_quiet: assert property (svc |=> (!$fell(resetPinN)) [*8]) else $error("serviced");
	chk_int_pair: assert property (internalReset == !resetPinN) else $error("pair");
	cov_svc: cover property (svc);
	cov_pulse: cover property ($rose(resetPinN));
	cov_rd: cover property (rd);
endmodule // wdt_timeout_monitor
bind wdt_timeout wdt_timeout_monitor i_wdt_timeout_monitor (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .resetPinN, .internalReset);

/* dv/tb_watchdog_timeout_counter.sv */
// self-checking bench for the watchdog block
`timescale 1ns/10ps
module tb_watchdog_timeout_counter;
	logic        clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, resetPinN;
	logic        stopExec, waitMode, monitorMode, breakActive, irqTestVoltage, rstTestVoltage, blankVectors;
	logic [15:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	int          failures, cmp_count, falls, n;
	// write flag, address, write data, expected read data
	logic [32:0] rows [5] = '{{1'b1, 16'hfff8, 8'h5a, 8'h00}, {1'b0, 16'hffff, 8'h00, 8'h5a},
		{1'b0, 16'h1234, 8'h00, 8'h00}, {1'b1, 16'hffff, 8'ha5, 8'h00}, {1'b0, 16'hffff, 8'h00, 8'h5a}};
	wdt_timeout #(.PORCYCLES(16)) i_wdt_timeout (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stopExec, .waitMode, .monitorMode, .blankVectors,
		.breakActive, .irqTestVoltage, .rstTestVoltage, .resetPinN, .internalReset());
	wdt_cpu_model i_wdt_cpu_model (.clock, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i);
	task ck(input bit ok, input string m);
		cmp_count++;
		if (!ok)
		begin
			failures++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task stop_test;
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task run(input int c);
		repeat (c) @(posedge clock);
	endtask
	task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		i_wdt_cpu_model.xfer(w, a, d, q);
	endtask
	task waitPin(input logic lv);
		n = 0;
		while (resetPinN !== lv && n < 9000)
		begin
			@(posedge clock);
			n++;
		end
	endtask
	task quiet(input string m);
		falls = 0;
		run(9000);
		ck(falls == 0, m);
	endtask
	always @(negedge resetPinN) falls++;
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		run(95000);
		failures++;
		stop_test();
	end
	initial
	begin
		nrst = 1'b0;
		{stopExec, waitMode, monitorMode, breakActive, irqTestVoltage, rstTestVoltage, blankVectors} = 7'h00;
		run(10);
		nrst <= 1'b1;
		run(3);
		foreach (rows[i])
		begin
			bus(rows[i][32], rows[i][31:16], {24'h000000, rows[i][15:8]});
			if (!rows[i][32])
				ck(q === {24'h000000, rows[i][7:0]}, "rd");
		end
		bus(1'b1, 16'hfff0, 32'h3);
		quiet("off");
		irqTestVoltage <= 1'b1;
		run(4);
		monitorMode <= 1'b1;
		bus(1'b1, 16'hfff0, 32'h2);
		quiet("mon");
		{monitorMode, irqTestVoltage, breakActive, rstTestVoltage} <= 4'h3;
		bus(1'b1, 16'hffff, 32'h0);
		quiet("brk");
		{breakActive, rstTestVoltage, waitMode} <= 3'h1;
		falls = 0;
		repeat (3)
		begin
			bus(1'b1, 16'hffff, 32'h0);
			run(4000);
		end
		ck(falls == 0, "svc");
		bus(1'b1, 16'hffff, 32'h0);
		waitPin(1'b0);
		ck(n > 8100 && n < 8200, "len");
		waitPin(1'b1);
		run(4);
		bus(1'b0, 16'hfff4, 32'h0);
		ck(q[0] === 1'b1, "flag");
		waitMode <= 1'b0;
		bus(1'b1, 16'hfff0, 32'h1);
		stopExec <= 1'b1;
		run(1);
		stopExec <= 1'b0;
		waitPin(1'b0);
		ck(n < 40, "stop");
		waitPin(1'b1);
		blankVectors <= 1'b1;
		monitorMode <= 1'b1;
		bus(1'b1, 16'hfff0, 32'h2);
		{blankVectors, monitorMode} <= 2'h0;
		quiet("blank");
		nrst <= 1'b0;
		run(2);
		ck(resetPinN === 1'b1 && wb_ack_o === 1'b0, "rst");
		nrst <= 1'b1;
		run(3);
		bus(1'b1, 16'hfff0, 32'h2);
		bus(1'b1, 16'hffff, 32'h0);
		waitPin(1'b0);
		ck(n > 8100 && n < 8200, "relock");
		waitPin(1'b1);
		stop_test();
	end
endmodule // tb_watchdog_timeout_counter
